// *** verilog/input_command_sequencer.sv ***
`timescale 1ns/1ps

// How it works
// RULE1: no-function mode ignores input, sends nothing.
// RULE2: contact type sets pressed polarity.
// RULE3: with distinction, classify first, then react.
// RULE4: long only when held at least threshold.
// RULE5: configurable delay between successive transmitted values.
// RULE6: flag picks single object or several.
// RULE7: multi-object mode skips objects not enabled.
// RULE8: each command has one of four formats.
// RULE9: short press sends step's short value.
// RULE10: long press sends step's long value.
// RULE11: debounce time selectable from eight values.
// RULE12: each press advances to next used command.
// RULE13: after last command, wrap to first enabled.
// RULE14: single object sends two to four values.
module input_command_sequencer #(
  parameter int TICKS = cmdseq_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic contact_pin,
  input cmdseq_pkg::sequence_config_type config_in,
  output cmdseq_pkg::telegram_type telegram,
  output logic pressed,
  output logic sending_pending
);
  import cmdseq_pkg::*;

  // The divider must produce a pulse at most every other cycle.
  if (TICKS < 2) begin : g_bad_ticks
    $error("TICKS must be at least two");
  end

  // Encodes a configured value in the selected bus format.
  function automatic logic [7:0] encode_value(input bus_value_format_type fmt,
                                              input logic [7:0] value);
    logic [15:0] scaled;
    scaled = 16'h0000;
    unique case (fmt)
      FORMAT_SWITCH: encode_value = {7'h00, value[0]}; // [RULE8]
      FORMAT_UNSIGNED: encode_value = value; // [RULE8]
      FORMAT_PERCENT: begin
        // Percent is scaled to a full byte, rounded to nearest.
        scaled = ({8'h00, value} * BYTE_FULL + 16'h0032) / {8'h00, PERCENT_FULL};
        encode_value = (value > PERCENT_FULL) ? 8'hFF : scaled[7:0]; // [RULE8]
      end
      FORMAT_HVAC: begin
        // Codes outside the mode range fall back to the nearest mode.
        if (value < HVAC_COMFORT) begin
          encode_value = HVAC_COMFORT; // [RULE8]
        end else if (value > HVAC_FROST) begin
          encode_value = HVAC_FROST; // [RULE8]
        end else begin
          encode_value = value; // [RULE8]
        end
      end
    endcase
  endfunction

  // Millisecond timebase divider.
  logic [$clog2(TICKS)-1:0] divider;
  logic [$clog2(TICKS)-1:0] next_divider;
  logic tick; // One-cycle pulse each millisecond.

  // Counts clock cycles down to the next tick.
  always_comb begin
    tick = (divider == '0);
    next_divider = tick ? ($clog2(TICKS))'(TICKS - 1) : divider - 1'b1;
  end

  // Divider register.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      divider <= '0;
    end else begin
      divider <= next_divider;
    end
  end

  logic contact_closed; // Debounced contact level.

  contact_debouncer debounce (
    .clock(clock),
    .reset(reset),
    .tick(tick),
    .contact_pin(contact_pin),
    .limit_ms(DEBOUNCE_MS[config_in.debounce_sel]),
    .stable(contact_closed)
  );

  // A normally closed contact reads as pressed when it opens.
  logic pressed_level;
  assign pressed_level = config_in.normally_closed ? ~contact_closed : contact_closed; // [RULE2]

  // Press classifier state.
  typedef enum logic [1:0] {PRESS_IDLE, PRESS_TIMING, PRESS_HELD} press_state_type;
  press_state_type press_state;
  press_state_type next_press_state;
  logic [15:0] held_ms; // Milliseconds the press has lasted.
  logic [15:0] next_held_ms;
  logic [15:0] long_limit; // Threshold clamped to its legal range.
  logic event_fire; // A classified actuation is ready.
  logic event_long; // The actuation was long.
  logic was_pressed; // Pressed level one cycle earlier.
  // Low only in the first cycle after reset. A normally closed contact that
  // is open at reset already reads as pressed, and without this the edge
  // detector would take that idle level for a fresh press.
  logic armed;

  // Threshold below the minimum is raised to the minimum.
  assign long_limit = (config_in.long_ms < LONG_MS_MIN) ? LONG_MS_MIN : config_in.long_ms;

  // Classifies each actuation as short or long before anything is sent.
  always_comb begin
    next_press_state = press_state;
    next_held_ms = held_ms;
    event_fire = 1'b0;
    event_long = 1'b0;
    if (!config_in.function_enabled) begin
      next_press_state = PRESS_IDLE; // [RULE1]
      next_held_ms = 16'h0000;
    end else begin
      unique case (press_state)
        PRESS_IDLE: begin
          if (pressed_level && !was_pressed && armed) begin
            if (config_in.distinguish_long) begin
              next_press_state = PRESS_TIMING; // [RULE3]
              next_held_ms = 16'h0000;
            end else begin
              // Without distinction the press itself is the event.
              event_fire = 1'b1; // [RULE9]
              next_press_state = PRESS_HELD;
            end
          end
        end
        PRESS_TIMING: begin
          if (!pressed_level) begin
            event_fire = 1'b1; // [RULE3]
            next_press_state = PRESS_IDLE;
          end else if (held_ms >= long_limit) begin
            event_fire = 1'b1; // [RULE4]
            event_long = 1'b1; // [RULE10]
            next_press_state = PRESS_HELD;
          end else if (tick && held_ms != LONG_MS_MAX) begin
            next_held_ms = held_ms + 16'h0001; // [RULE4]
          end
        end
        PRESS_HELD: begin
          // Wait for release so one press makes one event.
          if (!pressed_level) begin
            next_press_state = PRESS_IDLE;
          end
        end
      endcase
    end
  end

  // Classifier registers.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      press_state <= PRESS_IDLE;
      held_ms <= 16'h0000;
      was_pressed <= 1'b0;
      armed <= 1'b0;
    end else begin
      press_state <= next_press_state;
      held_ms <= next_held_ms;
      was_pressed <= pressed_level;
      armed <= 1'b1;
    end
  end

  // Sequencer state.
  logic [1:0] step; // Next step to consider.
  logic [1:0] next_step;
  logic [14:0] gap_ms; // Milliseconds left before another value may go.
  logic [14:0] next_gap_ms;
  logic pending; // An event waits for the gap to end.
  logic next_pending;
  logic pending_long;
  logic next_pending_long;
  telegram_type next_telegram;
  logic [2:0] count_clamped; // Single-object sequence length.
  logic [1:0] target; // Step chosen for this event.
  logic target_found;
  logic go_long;
  logic go;

  // Picks the step, encodes its value and spaces successive sends.
  always_comb begin
    next_step = step;
    next_gap_ms = gap_ms;
    next_pending = pending;
    next_pending_long = pending_long;
    next_telegram = '0;
    target = step;
    target_found = 1'b0;
    go = 1'b0;
    go_long = 1'b0;
    count_clamped = config_in.value_count;
    if (count_clamped < VALUE_COUNT_MIN) count_clamped = VALUE_COUNT_MIN;
    if (count_clamped > VALUE_COUNT_MAX) count_clamped = VALUE_COUNT_MAX;
    if (tick && gap_ms != 15'h0000) begin
      next_gap_ms = gap_ms - 15'h0001; // [RULE5]
    end
    if (event_fire) begin
      next_pending = 1'b1;
      next_pending_long = event_long;
    end
    if (!config_in.function_enabled) begin
      next_pending = 1'b0; // [RULE1]
    end else if (pending && gap_ms == 15'h0000) begin
      go = 1'b1; // [RULE5]
      go_long = pending_long;
      next_pending = event_fire;
    end
    if (config_in.single_object) begin
      // All values go to object A in turn.
      target = ({1'b0, step} < count_clamped) ? step : 2'h0; // [RULE14]
      target_found = 1'b1; // [RULE6]
    end else begin
      for (int i = 0; i < OBJECT_COUNT; i++) begin
        if (!target_found && config_in.object_used[2'(step + 2'(i))]) begin
          target = 2'(step + 2'(i)); // [RULE7]
          target_found = 1'b1;
        end
      end
    end
    if (go && target_found) begin
      next_telegram.valid = 1'b1;
      next_telegram.object = config_in.single_object ? 2'h0 : target; // [RULE6]
      next_telegram.bus_value_format = config_in.formats[target];
      next_telegram.data = encode_value(config_in.formats[target],
          (go_long && config_in.distinguish_long) ? config_in.long_values[target] // [RULE10]
                                                  : config_in.short_values[target]); // [RULE9]
      next_gap_ms = (config_in.delay_ms > DELAY_MS_MAX) ? DELAY_MS_MAX : config_in.delay_ms;
      if (config_in.single_object && ({1'b0, target} + 3'h1 >= count_clamped)) begin
        next_step = 2'h0; // [RULE13]
      end else begin
        next_step = target + 2'h1; // [RULE12]
      end
    end
  end

  // Sequencer registers; the telegram comes straight from flip-flops.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      step <= 2'h0;
      gap_ms <= DELAY_MS_DEFAULT;
      pending <= 1'b0;
      pending_long <= 1'b0;
      telegram <= '0;
      pressed <= 1'b0;
      sending_pending <= 1'b0;
    end else begin
      step <= next_step;
      gap_ms <= next_gap_ms;
      pending <= next_pending;
      pending_long <= next_pending_long;
      telegram <= next_telegram;
      pressed <= pressed_level & config_in.function_enabled;
      sending_pending <= next_pending;
    end
  end

endmodule // input_command_sequencer

// *** pkg/cmdseq_pkg.sv ***
package cmdseq_pkg;

  // Clock period of the system clock in nanoseconds.
  localparam int CLOCK_PERIOD_NS = 8;
  // Period of the millisecond timebase in nanoseconds.
  localparam int TICK_PERIOD_NS = 1_000_000;
  // Clock cycles per millisecond tick, rounded down.
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLOCK_PERIOD_NS;

  // Number of command objects in a sequence.
  localparam int OBJECT_COUNT = 4;

  // Long-press threshold limits and reset value, in milliseconds.
  localparam logic [15:0] LONG_MS_MIN = 16'h00C8;
  localparam logic [15:0] LONG_MS_DEFAULT = 16'h01F4;
  localparam logic [15:0] LONG_MS_MAX = 16'hFFFF;

  // Delay between commands, in milliseconds.
  localparam logic [14:0] DELAY_MS_DEFAULT = 15'h0000;
  localparam logic [14:0] DELAY_MS_MAX = 15'h4E20;

  // Selectable debounce times in milliseconds, indexed by the selector.
  localparam logic [7:0] DEBOUNCE_MS [8] = '{8'h0A, 8'h14, 8'h1E, 8'h28,
                                             8'h32, 8'h46, 8'h64, 8'h96};
  // Selector value of the 50 ms default.
  localparam logic [2:0] DEBOUNCE_DEFAULT_SEL = 3'h4;

  // Single-object sequence length limits.
  localparam logic [2:0] VALUE_COUNT_MIN = 3'h2;
  localparam logic [2:0] VALUE_COUNT_MAX = 3'h4;

  // Percentage scale: 100 percent maps onto a full byte.
  localparam logic [7:0] PERCENT_FULL = 8'h64;
  localparam logic [15:0] BYTE_FULL = 16'h00FF;

  // Building-mode codes carried in the mode format.
  localparam logic [7:0] HVAC_COMFORT = 8'h01;
  localparam logic [7:0] HVAC_FROST = 8'h04;

  // Data format of one command object.
  typedef enum logic [1:0] {
    FORMAT_SWITCH,
    FORMAT_UNSIGNED,
    FORMAT_PERCENT,
    FORMAT_HVAC
  } bus_value_format_type;

  // Complete configuration of one command-sequence input.
  typedef struct packed {
    logic function_enabled;
    logic normally_closed;
    logic distinguish_long;
    logic [15:0] long_ms;
    logic [14:0] delay_ms;
    logic single_object;
    logic [3:0] object_used;
    logic [2:0] value_count;
    logic [2:0] debounce_sel;
    bus_value_format_type [3:0] formats;
    logic [3:0][7:0] short_values;
    logic [3:0][7:0] long_values;
  } sequence_config_type;

  // One value handed to the bus telegram sender.
  typedef struct packed {
    logic valid;
    logic [1:0] object;
    bus_value_format_type bus_value_format;
    logic [7:0] data;
  } telegram_type;

endpackage

// *** verilog/contact_debouncer.sv ***
`timescale 1ns/1ps

// Synchronises the raw contact and accepts a new level only once it has
// held steady for the selected number of millisecond ticks.
module contact_debouncer (
  input wire logic clock,
  input wire logic reset,
  input wire logic tick,
  input wire logic contact_pin,
  input wire logic [7:0] limit_ms,
  output logic stable
);
  import cmdseq_pkg::*;

  logic sync_first; // First synchroniser stage, read only by the second.
  logic sync_second; // Contact level in the clock domain.
  logic [7:0] count; // Milliseconds the new level has held.
  logic [7:0] next_count;
  logic next_stable;

  // Two-stage synchroniser for the asynchronous contact.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync_first <= 1'b0;
      sync_second <= 1'b0;
    end else begin
      sync_first <= contact_pin;
      sync_second <= sync_first;
    end
  end

  // Any bounce back to the accepted level restarts the count, so a
  // bouncing contact never produces a second edge.
  always_comb begin
    next_count = count;
    next_stable = stable;
    if (sync_second == stable) begin
      next_count = 8'h00;
    end else if (tick) begin
      if (count + 8'h01 >= limit_ms) begin
        next_stable = sync_second; // [RULE11]
        next_count = 8'h00;
      end else begin
        next_count = count + 8'h01;
      end
    end
  end

  // Debounce state registers.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count <= 8'h00;
      stable <= 1'b0;
    end else begin
      count <= next_count;
      stable <= next_stable;
    end
  end

endmodule // contact_debouncer

// *** verif/contact_model.sv ***
`timescale 1ns/1ps

// Mechanical contact: every change of state rattles for a few cycles.
module contact_model (
  input wire logic clock,
  input wire logic closed,
  output logic contact_pin
);
  logic last; // Settled state of the contact.
  int n; // Bounce cycles left.
  initial begin
    contact_pin = 1'b0;
    last = 1'b0;
    n = 0;
  end
  // The bounce is kept shorter than the shortest debounce time.
  always @(posedge clock) begin
    if (closed !== last) begin
      last <= closed;
      n <= 6;
      contact_pin <= ~contact_pin;
    end else if (n > 0) begin
      n <= n - 1;
      contact_pin <= n[0] ? closed : ~closed;
    end else contact_pin <= last;
  end
endmodule // contact_model

// *** verif/input_command_sequencer_asserts.sv ***
`timescale 1ns/1ps

// Port checker for the sequencer.
module input_command_sequencer_asserts #(
  parameter int TICKS = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic contact_pin,
  input cmdseq_pkg::sequence_config_type config_in,
  input cmdseq_pkg::telegram_type telegram,
  input wire logic pressed,
  input wire logic sending_pending
);
  import cmdseq_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Cycles since the last send; saturates low so an add cannot wrap.
  logic [31:0] gap;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) gap <= 32'h00FFFFFF;
    else if (telegram.valid) gap <= 32'h00000001;
    else if (gap != 32'h00FFFFFF) gap <= gap + 32'h00000001;
  end
  sequence s_sent;
    telegram.valid;
  endsequence
  property p_pulse; s_sent |=> !telegram.valid; endproperty
  property p_off;
    !config_in.function_enabled && !$past(config_in.function_enabled)
      |-> !telegram.valid && !pressed;
  endproperty
  property p_single; s_sent ##0 config_in.single_object |-> telegram.object == 2'h0; endproperty
  property p_used;
    s_sent ##0 !config_in.single_object |-> config_in.object_used[telegram.object];
  endproperty
  property p_switch;
    s_sent ##0 telegram.bus_value_format == FORMAT_SWITCH |-> telegram.data[7:1] == 7'h00;
  endproperty
  property p_hvac;
    s_sent ##0 telegram.bus_value_format == FORMAT_HVAC
      |-> telegram.data >= HVAC_COMFORT && telegram.data <= HVAC_FROST;
  endproperty
  property p_short;
    s_sent ##0 (!config_in.distinguish_long && !config_in.single_object &&
      telegram.bus_value_format == FORMAT_UNSIGNED)
      |-> telegram.data == config_in.short_values[telegram.object];
  endproperty
  property p_gap; s_sent |-> gap + TICKS > config_in.delay_ms * TICKS; endproperty
  property p_format;
    s_sent ##0 !config_in.single_object
      |-> telegram.bus_value_format == config_in.formats[telegram.object];
  endproperty
  a_pulse: assert property (p_pulse) else $error("send longer than a cycle");
  a_off: assert property (p_off) else $error("activity with no function");
  a_single: assert property (p_single) else $error("wrong object in single mode");
  a_used: assert property (p_used) else $error("disabled object sent");
  a_switch: assert property (p_switch) else $error("switch value not one bit");
  a_hvac: assert property (p_hvac) else $error("mode code out of range");
  a_short: assert property (p_short) else $error("short value wrong");
  a_gap: assert property (p_gap) else $error("sends closer than the delay");
  a_format: assert property (p_format) else $error("format not the object's own");
endmodule // input_command_sequencer_asserts

bind input_command_sequencer input_command_sequencer_asserts #(.TICKS(TICKS)) u_asserts (
  .clock(clock), .reset(reset), .contact_pin(contact_pin), .config_in(config_in),
  .telegram(telegram), .pressed(pressed), .sending_pending(sending_pending));

// *** verif/tb_top.sv ***
`timescale 1ns/1ps

// Self-checking bench; a millisecond is four cycles here to keep runs short.
module tb_top;
  import cmdseq_pkg::*;
  localparam int TICKS = 4;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic closed = 1'b0; // Wanted contact state.
  logic contact_pin;
  sequence_config_type cfg;
  telegram_type telegram;
  logic pressed;
  logic sending_pending;
  telegram_type got[$]; // Sends seen, oldest first.
  int at[$]; // Cycle of each send.
  int cyc = 0;
  int n_fail = 0;
  int cmp_count = 0;
  always #4 clock = ~clock;
  contact_model u_contact_model (.clock(clock), .closed(closed), .contact_pin(contact_pin));
  input_command_sequencer #(.TICKS(TICKS)) u_input_command_sequencer (.clock(clock),
    .reset(reset), .contact_pin(contact_pin), .config_in(cfg), .telegram(telegram),
    .pressed(pressed), .sending_pending(sending_pending));
  // Capture sends; the cycle ceiling is far above the whole run.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (telegram.valid === 1'b1) begin
      got.push_back(telegram);
      at.push_back(cyc);
    end
    if (cyc == 40000) begin
      n_fail++;
      finish_test();
    end
  end
  task finish_test;
    $display("Checks %0d, errors %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Moves the contact, then waits n cycles.
  task hold(input logic lv, input int n);
    @(posedge clock);
    #1 closed = lv;
    repeat (n) @(posedge clock);
  endtask
  task press;
    hold(1'b1, 60);
    hold(1'b0, 60);
  endtask
  // New settings are applied only under reset.
  task start(input sequence_config_type c);
    @(posedge clock);
    #1 reset = 1'b1;
    cfg = c;
    repeat (8) @(posedge clock);
    #1 reset = 1'b0;
    got.delete();
    at.delete();
  endtask
  task take(input logic [1:0] o, input logic [7:0] d);
    telegram_type t;
    chk("sent", 16'h0001, {15'h0000, got.size() > 0});
    if (got.size() > 0) begin
      t = got.pop_front();
      chk("object", {14'h0000, o}, {14'h0000, t.object});
      chk("data", {8'h00, d}, {8'h00, t.data});
    end
  endtask
  task none;
    chk("quiet", 16'h0000, 16'(got.size()));
  endtask
  function automatic sequence_config_type base();
    sequence_config_type c;
    c = '0;
    c.function_enabled = 1'b1;
    c.long_ms = LONG_MS_MIN;
    c.value_count = VALUE_COUNT_MIN;
    for (int i = 0; i < 4; i++) c.formats[i] = FORMAT_UNSIGNED;
    return c;
  endfunction
  task s_multi;
    sequence_config_type c;
    c = base();
    c.object_used = 4'hD;
    c.formats[0] = FORMAT_SWITCH;
    c.formats[2] = FORMAT_PERCENT;
    c.formats[3] = FORMAT_HVAC;
    c.short_values = {8'h04, 8'h55, 8'h14, 8'h03};
    start(c);
    repeat (4) press();
    take(2'h0, 8'h01);
    take(2'h2, 8'hD9);
    take(2'h3, 8'h04);
    take(2'h0, 8'h01);
    none();
  endtask
  task s_long;
    sequence_config_type c;
    c = base();
    c.distinguish_long = 1'b1;
    c.object_used = 4'h1;
    c.short_values[0] = 8'h11;
    c.long_values[0] = 8'h22;
    start(c);
    hold(1'b1, 700);
    none();
    hold(1'b0, 60);
    take(2'h0, 8'h11);
    hold(1'b1, 900);
    take(2'h0, 8'h22);
    hold(1'b0, 60);
    none();
  endtask
  task s_single;
    sequence_config_type c;
    c = base();
    c.single_object = 1'b1;
    c.value_count = 3'h3;
    c.short_values = {8'h44, 8'h0C, 8'h0B, 8'h0A};
    start(c);
    repeat (4) press();
    take(2'h0, 8'h0A);
    take(2'h0, 8'h0B);
    take(2'h0, 8'h0C);
    take(2'h0, 8'h0A);
    none();
  endtask
  task s_off;
    sequence_config_type c;
    c = base();
    c.function_enabled = 1'b0;
    c.object_used = 4'h1;
    start(c);
    hold(1'b1, 60);
    chk("pressed", 16'h0000, {15'h0000, pressed});
    hold(1'b0, 60);
    none();
    c.function_enabled = 1'b1;
    c.normally_closed = 1'b1;
    c.short_values[0] = 8'h77;
    start(c);
    hold(1'b1, 60);
    none();
    hold(1'b0, 60);
    chk("pressed", 16'h0001, {15'h0000, pressed});
    take(2'h0, 8'h77);
    hold(1'b1, 60);
    none();
  endtask
  task s_delay;
    sequence_config_type c;
    c = base();
    c.delay_ms = 15'h0032;
    c.object_used = 4'h3;
    c.short_values = {8'h00, 8'h00, 8'h0B, 8'h0A};
    start(c);
    press();
    hold(1'b1, 60);
    chk("pending", 16'h0001, {15'h0000, sending_pending});
    hold(1'b0, 100);
    chk("gap", 16'h0001, {15'h0000, at[1] - at[0] >= 196 && at[1] - at[0] <= 210});
    take(2'h0, 8'h0A);
    take(2'h1, 8'h0B);
  endtask
  // Longest debounce time: a closure shorter than it is ignored, a longer one counts.
  task s_bounce;
    sequence_config_type c;
    c = base();
    c.debounce_sel = 3'h7;
    c.object_used = 4'h1;
    c.short_values[0] = 8'h5A;
    start(c);
    hold(1'b1, 560);
    chk("pressed", 16'h0000, {15'h0000, pressed});
    hold(1'b0, 660);
    none();
    hold(1'b1, 660);
    chk("pressed", 16'h0001, {15'h0000, pressed});
    take(2'h0, 8'h5A);
    hold(1'b0, 660);
  endtask
  initial begin
    cfg = base();
    s_multi();
    s_long();
    s_single();
    s_off();
    s_delay();
    s_bounce();
    finish_test();
  end
endmodule // tb_top
